//--- hw/pat_pkg.sv
package pat_pkg;
   // APB register map, byte addresses
   localparam logic [7:0] PAT_CTRL_OFS = 8'h00;
   localparam logic [7:0] PAT_LAMPS_OFS = 8'h04;
   localparam logic [7:0] PAT_FAULT_OFS = 8'h08;
   localparam logic [7:0] PAT_INPUTS_OFS = 8'h0c;

   // Control register fields
   localparam int PAT_CTRL_LT_BIT = 0;
   localparam int PAT_CTRL_ST_BIT = 1;
   localparam int PAT_CTRL_CLR_BIT = 2;
   localparam logic [1:0] PAT_CTRL_RST = 2'h0;

   // Error clear pulse length
   localparam int PAT_CLK_NS = 50;
   localparam int PAT_CLR_PULSE_NS = 1000;
   localparam int PAT_CLR_CYCLES = (PAT_CLR_PULSE_NS + PAT_CLK_NS - 1) / PAT_CLK_NS;

   // Remote alarm pair indices
   localparam int PAT_RA_CARD = 0;
   localparam int PAT_RA_OOT = 1;
   localparam int PAT_RA_LINK = 2;
   localparam int PAT_RA_FRB = 3;
   localparam int PAT_RA_FRA = 4;
   localparam int PAT_RA_PSU = 5;
   localparam int PAT_RA_TEMP = 6;
   localparam int PAT_RA_NUM = 7;

   // Remote pair at rest, bit order complement then true
   localparam logic [1:0] PAT_PAIR_IDLE = 2'h2;

   // Segment patterns, bit order g f e d c b a
   localparam logic [6:0] PAT_SEG_ALL = 7'h7f;
   localparam logic [6:0] PAT_SEG_BLANK = 7'h00;

   // Lamp enables arriving from the display card
   typedef struct packed {
      logic demux_card_fault_lamp_en;
      logic mux_out_of_tol_flag;
      logic mux_card_fault_lamp_en;
      logic demux_timing_loss_lamp_en;
      logic mux_timing_loss_lamp_en;
   } pat_disp_t;

   // Faulty card address from the display card
   typedef struct packed {
      logic tens_addr_bit1;
      logic tens_addr_bit0;
      logic units_addr_bit3;
      logic units_addr_bit2;
      logic units_addr_bit1;
      logic units_addr_bit0;
   } pat_addr_t;

   // Front panel lamps
   typedef struct packed {
      logic power_on;
      logic psu;
      logic temperature;
      logic link_error;
      logic frame_b_loss;
      logic frame_a_loss;
      logic mux_timing_loss;
      logic demux_timing_loss;
      logic mux_card;
      logic mux_out_of_tol;
      logic demux_card;
   } pat_lamps_t;

   // Error clear lines to all cards
   typedef struct packed {
      logic mux_error_clear;
      logic mux_error_clear_n;
      logic demux_error_clear;
      logic demux_error_clear_n;
   } pat_clear_t;
endpackage

//--- hw/pat_ctrl.sv
// Our own choices: the address map and the APB register port.
`timescale 1ns/1ps
module pat_ctrl #(
   parameter int CLR_CYCLES = pat_pkg::PAT_CLR_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire pat_pkg::pat_disp_t disp_lamps,
   input wire pat_pkg::pat_addr_t fault_addr,
   input wire logic card_fault_in,
   input wire logic overtemp_n,
   input wire logic psu_failure_in,
   input wire logic lamp_test_req,
   input wire logic self_test_switch_on,
   input wire logic error_clear_switch,
   input wire logic link_error_detect,
   input wire logic frame_b_loss_in,
   input wire logic demux_timing_loss_alarm_n,
   input wire logic frame_a_loss_in,
   output pat_pkg::pat_lamps_t lamps,
   output logic [6:0] tens_seg,
   output logic [6:0] units_seg,
   output logic psu_inhibit,
   output logic [1:0] remote_card_fault_pair,
   output logic [1:0] remote_out_of_tol_pair,
   output logic [1:0] remote_link_error_pair,
   output logic [1:0] remote_frame_b_loss_pair,
   output logic [1:0] remote_frame_a_loss_pair,
   output logic [1:0] remote_psu_failure_pair,
   output logic [1:0] remote_overtemp_pair,
   output logic self_test_line_a,
   output logic self_test_line_b,
   output pat_pkg::pat_clear_t err_clear
);
   import pat_pkg::*;

   // Elaboration check: the 16-bit stretch counter must load at least one cycle
   if (CLR_CYCLES < 1 || CLR_CYCLES > 65535) begin : g_bad_clr
      $error("CLR_CYCLES out of range");
   end

   logic [1:0] ctrl_q;
   logic clr_req_q;
   logic st_prev_q;
   logic [15:0] clr_cnt_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   pat_lamps_t lamps_q;
   pat_clear_t clear_q;
   logic [6:0] tens_q;
   logic [6:0] units_q;
   logic inhibit_q;
   logic st_a_q;
   logic st_b_q;
   logic [1:0] pair_q [PAT_RA_NUM];
   logic [PAT_RA_NUM-1:0] ra_cond;
   logic lt_eff;
   logic st_eff;
   logic hot;
   logic wr_en;
   logic setup;
   logic addr_hit;

   // Lamp test and self test come from the panel switch or from software
   assign lt_eff = lamp_test_req | ctrl_q[PAT_CTRL_LT_BIT];
   assign st_eff = self_test_switch_on | ctrl_q[PAT_CTRL_ST_BIT];
   assign hot = ~overtemp_n;
   assign setup = psel & ~penable;
   assign wr_en = psel & penable & pready_q & pwrite;
   assign addr_hit = (paddr == PAT_CTRL_OFS) || (paddr == PAT_LAMPS_OFS) ||
                     (paddr == PAT_FAULT_OFS) || (paddr == PAT_INPUTS_OFS);

   // Seven segment decode; codes outside 0-9 blank the numeral
   function automatic logic [6:0] seg7(input logic [3:0] d);
      logic [6:0] s;
      s = PAT_SEG_BLANK;
      case (d)
         4'h0: s = 7'h3f;
         4'h1: s = 7'h06;
         4'h2: s = 7'h5b;
         4'h3: s = 7'h4f;
         4'h4: s = 7'h66;
         4'h5: s = 7'h6d;
         4'h6: s = 7'h7d;
         4'h7: s = 7'h07;
         4'h8: s = 7'h7f;
         4'h9: s = 7'h6f;
         default: s = PAT_SEG_BLANK;
      endcase
      return s;
   endfunction

   // APB slave: one setup cycle, then an access cycle with pready high
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0;
      end else begin
         pready_q <= setup;
         pslverr_q <= setup & ~addr_hit;
         if (setup && !pwrite) begin
            if (paddr == PAT_CTRL_OFS) begin
               prdata_q <= {30'h0, ctrl_q};
            end else if (paddr == PAT_LAMPS_OFS) begin
               prdata_q <= {21'h0, lamps_q};
            end else if (paddr == PAT_FAULT_OFS) begin
               prdata_q <= {18'h0, tens_q, units_q};
            end else if (paddr == PAT_INPUTS_OFS) begin
               prdata_q <= {26'h0, fault_addr};
            end else begin
               prdata_q <= 32'h0;
            end
         end else begin
            prdata_q <= 32'h0;
         end
      end
   end

   // Control register; the clear bit is a self-clearing trigger
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= PAT_CTRL_RST;
         clr_req_q <= 1'b0;
      end else begin
         clr_req_q <= 1'b0;
         if (wr_en && paddr == PAT_CTRL_OFS) begin
            ctrl_q <= pwdata[1:0];
            clr_req_q <= pwdata[PAT_CTRL_CLR_BIT];
         end
      end
   end

   // Error clear stretch: a short switch bounce still gives a full pulse
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_prev_q <= 1'b0;
         clr_cnt_q <= 16'h0;
      end else begin
         st_prev_q <= st_eff;
         if ((st_prev_q && !st_eff) || error_clear_switch || clr_req_q) begin
            clr_cnt_q <= 16'(CLR_CYCLES);
         end else if (clr_cnt_q != 16'h0) begin
            clr_cnt_q <= clr_cnt_q - 16'h1;
         end
      end
   end

   // Clear lines, true and complement
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clear_q <= '{mux_error_clear: 1'b0, mux_error_clear_n: 1'b1,
                      demux_error_clear: 1'b0, demux_error_clear_n: 1'b1};
      end else begin
         clear_q.mux_error_clear <= (clr_cnt_q != 16'h0);
         clear_q.mux_error_clear_n <= (clr_cnt_q == 16'h0);
         clear_q.demux_error_clear <= (clr_cnt_q != 16'h0);
         clear_q.demux_error_clear_n <= (clr_cnt_q == 16'h0);
      end
   end

   // Self-test lines, identical by construction
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_a_q <= 1'b0;
         st_b_q <= 1'b0;
      end else begin
         st_a_q <= st_eff;
         st_b_q <= st_eff;
      end
   end

   // Thermal control: inhibit follows overtemperature only, never lamp test
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         inhibit_q <= 1'b0;
      end else begin
         inhibit_q <= hot;
      end
   end

   // Conditions behind the remote alarm pairs
   assign ra_cond[PAT_RA_CARD] = card_fault_in;
   assign ra_cond[PAT_RA_OOT] = disp_lamps.mux_out_of_tol_flag;
   assign ra_cond[PAT_RA_LINK] = link_error_detect;
   assign ra_cond[PAT_RA_FRB] = frame_b_loss_in | ~demux_timing_loss_alarm_n;
   assign ra_cond[PAT_RA_FRA] = frame_a_loss_in;
   assign ra_cond[PAT_RA_PSU] = psu_failure_in;
   assign ra_cond[PAT_RA_TEMP] = hot;

   // Two flops per remote alarm, true and complement, so no gate sits before the pins
   genvar gi;
   generate
      for (gi = 0; gi < PAT_RA_NUM; gi++) begin : g_ra
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               pair_q[gi] <= PAT_PAIR_IDLE;
            end else begin
               pair_q[gi] <= {~ra_cond[gi], ra_cond[gi]};
            end
         end
      end
   endgenerate

   // Panel lamps: real error ORed with lamp test, so errors stay lit after it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lamps_q <= '0;
      end else begin
         lamps_q.demux_card <= disp_lamps.demux_card_fault_lamp_en | lt_eff;
         lamps_q.mux_out_of_tol <= disp_lamps.mux_out_of_tol_flag | lt_eff;
         lamps_q.mux_card <= disp_lamps.mux_card_fault_lamp_en | lt_eff;
         lamps_q.demux_timing_loss <= disp_lamps.demux_timing_loss_lamp_en | lt_eff;
         lamps_q.mux_timing_loss <= disp_lamps.mux_timing_loss_lamp_en | lt_eff;
         lamps_q.frame_a_loss <= ra_cond[PAT_RA_FRA] | lt_eff;
         lamps_q.frame_b_loss <= ra_cond[PAT_RA_FRB] | lt_eff;
         lamps_q.link_error <= ra_cond[PAT_RA_LINK] | lt_eff;
         lamps_q.temperature <= hot | lt_eff | st_eff;
         lamps_q.psu <= psu_failure_in | lt_eff;
         lamps_q.power_on <= ~hot; // Supply on unless thermally inhibited
      end
   end

   // Fault location readout, forced to 88 in lamp test
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tens_q <= PAT_SEG_BLANK;
         units_q <= PAT_SEG_BLANK;
      end else if (lt_eff) begin
         tens_q <= PAT_SEG_ALL;
         units_q <= PAT_SEG_ALL;
      end else begin
         tens_q <= seg7({2'b00, fault_addr.tens_addr_bit1, fault_addr.tens_addr_bit0});
         units_q <= seg7(fault_addr[3:0]);
      end
   end

   // Outputs straight from flops
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign lamps = lamps_q;
   assign tens_seg = tens_q;
   assign units_seg = units_q;
   assign psu_inhibit = inhibit_q;
   assign self_test_line_a = st_a_q;
   assign self_test_line_b = st_b_q;
   assign err_clear = clear_q;
   assign remote_card_fault_pair = pair_q[PAT_RA_CARD];
   assign remote_out_of_tol_pair = pair_q[PAT_RA_OOT];
   assign remote_link_error_pair = pair_q[PAT_RA_LINK];
   assign remote_frame_b_loss_pair = pair_q[PAT_RA_FRB];
   assign remote_frame_a_loss_pair = pair_q[PAT_RA_FRA];
   assign remote_psu_failure_pair = pair_q[PAT_RA_PSU];
   assign remote_overtemp_pair = pair_q[PAT_RA_TEMP];
endmodule // pat_ctrl

//--- test/pat_ctrl_checker.sv
`timescale 1ns/1ps
// Watches the panel outputs against their input causes, one cycle on, error clears one to four cycles on
module pat_ctrl_checker #(
   parameter int CLR_CYCLES = 2
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire pat_pkg::pat_disp_t disp_lamps,
   input wire logic card_fault_in,
   input wire logic overtemp_n,
   input wire logic lamp_test_req,
   input wire logic self_test_switch_on,
   input wire logic error_clear_switch,
   input wire logic link_error_detect,
   input wire logic frame_b_loss_in,
   input wire logic demux_timing_loss_alarm_n,
   input wire logic frame_a_loss_in,
   input wire pat_pkg::pat_lamps_t lamps,
   input wire logic [6:0] tens_seg,
   input wire logic [6:0] units_seg,
   input wire logic psu_inhibit,
   input wire logic [1:0] remote_card_fault_pair,
   input wire logic [1:0] remote_link_error_pair,
   input wire logic [1:0] remote_frame_b_loss_pair,
   input wire logic [1:0] remote_overtemp_pair,
   input wire logic self_test_line_a,
   input wire logic self_test_line_b,
   input wire pat_pkg::pat_clear_t err_clear
);
   import pat_pkg::*;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Panel lamps and alarms
   disp_lamp_a: assert property (disp_lamps.mux_card_fault_lamp_en |=> lamps.mux_card)
      else $error("mux card lamp dark");
   hot_inhibit_a: assert property (!overtemp_n |=> psu_inhibit && lamps.temperature)
      else $error("supply not inhibited on overheat");
   hot_remote_a: assert property (!overtemp_n |=> remote_overtemp_pair == 2'b01)
      else $error("overheat pair idle");
   lamp_test_a: assert property (lamp_test_req |=> &lamps[9:0] && {tens_seg, units_seg} == 14'h3fff)
      else $error("lamp test incomplete");
   self_test_a: assert property (self_test_switch_on |=> self_test_line_a && lamps.temperature)
      else $error("self test not driven");
   st_same_a: assert property (self_test_line_a == self_test_line_b)
      else $error("self test lines differ");
   card_pair_a: assert property (card_fault_in |=> remote_card_fault_pair == 2'b01)
      else $error("card fault pair idle");
   link_pair_a: assert property (link_error_detect |=> remote_link_error_pair == 2'b01 && lamps.link_error)
      else $error("link error not raised");
   frame_b_a: assert property ((frame_b_loss_in || !demux_timing_loss_alarm_n) |=>
      remote_frame_b_loss_pair == 2'b01 && lamps.frame_b_loss) else $error("frame b alarm missing");
   // Error clears follow their triggers
   clear_sw_a: assert property (error_clear_switch |-> ##[1:4] err_clear == 4'b1010)
      else $error("display reset gave no clear");
   st_off_a: assert property ($fell(self_test_switch_on) |-> ##[1:4] err_clear.demux_error_clear)
      else $error("self test off gave no clear");
   lt_cov: cover property (lamp_test_req ##1 lamps.frame_a_loss);
   st_cov: cover property ($fell(self_test_switch_on));
   clr_cov: cover property ($rose(err_clear.mux_error_clear));
endmodule // pat_ctrl_checker

//--- test/pat_panel_model.sv
`timescale 1ns/1ps
// Front panel switches; clean contacts, so no debounce is modelled
module pat_panel_model (
   input wire logic lt_cmd,
   input wire logic st_cmd,
   input wire logic clr_cmd,
   output logic lamp_test_req,
   output logic self_test_switch_on,
   output logic error_clear_switch
);
   // Switch levels straight onto the panel lines
   assign lamp_test_req = lt_cmd;
   assign self_test_switch_on = st_cmd;
   assign error_clear_switch = clr_cmd;
endmodule // pat_panel_model

//--- test/tb_panel_alarm_test_control.sv
`timescale 1ns/1ps
bind pat_ctrl pat_ctrl_checker #(.CLR_CYCLES(CLR_CYCLES)) chk (.*);
module tb_panel_alarm_test_control;
   import pat_pkg::*;
   localparam int CLR = 2;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er, lt_cmd = 0, st_cmd = 0, clr_cmd = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, psu_inhibit, self_test_line_a, self_test_line_b;
   pat_disp_t disp_lamps = '0;
   pat_addr_t fault_addr = '0;
   logic card_fault_in = 0, overtemp_n = 1, psu_failure_in = 0, link_error_detect = 0, frame_b_loss_in = 0;
   logic demux_timing_loss_alarm_n = 1, frame_a_loss_in = 0, lamp_test_req, self_test_switch_on, error_clear_switch;
   pat_lamps_t lamps;
   logic [6:0] tens_seg, units_seg;
   logic [1:0] remote_card_fault_pair, remote_out_of_tol_pair, remote_link_error_pair, remote_frame_b_loss_pair;
   logic [1:0] remote_frame_a_loss_pair, remote_psu_failure_pair, remote_overtemp_pair;
   pat_clear_t err_clear;
   int error_cnt = 0, check_count = 0, sw_lt = 0, sw_st = 0;
   logic [6:0] seg_tab [10] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07, 7'h7f, 7'h6f};
   pat_ctrl #(.CLR_CYCLES(CLR)) DUT (.*);
   pat_panel_model PANEL (.*);
   initial forever #25 pclk = ~pclk;
   task check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task conclude;
      if (error_cnt == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // One APB transfer; holds everything until pready is seen
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
      int n;
      n = 0;
      psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
      if (n >= 20) error_cnt++;
      r = prdata;
      e = pslverr;
      psel <= 0; penable <= 0;
      @(posedge pclk);
   endtask
   // Reference lamp vector from the current inputs
   function automatic logic [10:0] exp_lamps(input logic lt, input logic st);
      return {overtemp_n, psu_failure_in | lt, !overtemp_n | lt | st, link_error_detect | lt,
              frame_b_loss_in | !demux_timing_loss_alarm_n | lt, frame_a_loss_in | lt,
              disp_lamps.mux_timing_loss_lamp_en | lt, disp_lamps.demux_timing_loss_lamp_en | lt,
              disp_lamps.mux_card_fault_lamp_en | lt, disp_lamps.mux_out_of_tol_flag | lt,
              disp_lamps.demux_card_fault_lamp_en | lt};
   endfunction
   function automatic logic [1:0] pr(input logic x);
      return {!x, x};
   endfunction
   // Inputs settle mid-cycle, outputs compared one edge later
   task check_panel;
      logic lt;
      logic st;
      @(negedge pclk);
      lt = lamp_test_req | sw_lt[0];
      st = self_test_switch_on | sw_st[0];
      @(posedge pclk); #1;
      check(lamps, exp_lamps(lt, st));
      check({tens_seg, units_seg}, lt ? 14'h3fff : {seg_tab[fault_addr[5:4]], seg_tab[fault_addr[3:0]]});
      check(psu_inhibit, !overtemp_n);
      check({remote_card_fault_pair, remote_out_of_tol_pair, remote_link_error_pair, remote_frame_b_loss_pair,
             remote_frame_a_loss_pair, remote_psu_failure_pair, remote_overtemp_pair},
            {pr(card_fault_in), pr(disp_lamps.mux_out_of_tol_flag), pr(link_error_detect),
             pr(frame_b_loss_in | !demux_timing_loss_alarm_n), pr(frame_a_loss_in), pr(psu_failure_in),
             pr(!overtemp_n)});
      check({self_test_line_a, self_test_line_b}, {2{st}});
   endtask
   // Waits for a clear pulse and measures its length
   task clear_pulse;
      int n, len;
      n = 0; len = 0;
      while (err_clear !== 4'b1010 && n < 10) begin @(posedge pclk); #1; n++; end
      while (err_clear === 4'b1010 && len < 50) begin @(posedge pclk); #1; len++; end
      check(len, CLR);
      check(err_clear, 4'h5);
      @(posedge pclk);
   endtask
   initial begin
      #1000000;
      error_cnt++;
      conclude;
   end
   initial begin
      void'($urandom(32'h093b));
      repeat (8) @(posedge pclk);
      presetn <= 1;
      apb(0, PAT_CTRL_OFS, 0, rd, er);
      check(rd, 0);
      repeat (150) begin
         @(posedge pclk);
         disp_lamps <= 5'($urandom);
         fault_addr <= {2'($urandom % 3), 4'($urandom % 10)};
         {card_fault_in, overtemp_n, psu_failure_in, link_error_detect, frame_b_loss_in,
          demux_timing_loss_alarm_n, frame_a_loss_in} <= 7'($urandom);
         lt_cmd <= ($urandom % 4) == 0;
         st_cmd <= ($urandom % 4) == 0;
         check_panel;
      end
      @(posedge pclk);
      {lt_cmd, st_cmd, disp_lamps, card_fault_in, psu_failure_in, link_error_detect, frame_b_loss_in} <= '0;
      {overtemp_n, demux_timing_loss_alarm_n, frame_a_loss_in} <= 3'b110;
      check_panel;
      repeat (30) @(posedge pclk);
      clr_cmd <= 1;
      @(posedge pclk);
      clr_cmd <= 0;
      clear_pulse;
      st_cmd <= 1;
      repeat (3) @(posedge pclk);
      st_cmd <= 0;
      clear_pulse;
      apb(1, PAT_CTRL_OFS, 32'h5, rd, er);
      sw_lt = 1;
      clear_pulse;
      check_panel;
      @(posedge pclk);
      apb(0, PAT_CTRL_OFS, 0, rd, er);
      check(rd, 1);
      apb(0, PAT_LAMPS_OFS, 0, rd, er);
      check(rd, exp_lamps(1, 0));
      apb(0, PAT_FAULT_OFS, 0, rd, er);
      check(rd, 32'h3fff);
      apb(0, PAT_INPUTS_OFS, 0, rd, er);
      check(er, 1'b0);
      check(rd, {26'h0, fault_addr});
      apb(0, 8'h10, 0, rd, er);
      check(er, 1'b1);
      check(rd, 32'h0);
      apb(1, PAT_CTRL_OFS, 32'h2, rd, er);
      sw_lt = 0;
      sw_st = 1;
      check_panel;
      @(posedge pclk);
      apb(1, PAT_CTRL_OFS, 32'h0, rd, er);
      sw_st = 0;
      clear_pulse;
      presetn <= 0;
      repeat (2) @(posedge pclk);
      presetn <= 1;
      sw_lt = 0;
      apb(0, PAT_CTRL_OFS, 0, rd, er);
      check(rd, 0);
      conclude;
   end
endmodule // tb_panel_alarm_test_control
